// ===== rtl/laser_driver_status_packet.sv
/*
 Frames the first status packet of the laser driver into a byte stream.
 Assumes a byte sink with valid/ready outside; all inputs are synchronous to clock_i.
*/
`timescale 1ns/1ps
module laser_driver_status_packet #(
    parameter bit PANEL_SP_EN = 1'b0
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic send_i,
    input wire logic [7:0] control_byte_i,
    input wire logic [7:0] op_mode_byte_i,
    input wire logic [1:0] limit_src_i,
    input wire logic [2:0] setpoint_src_i,
    input wire logic [2:0] temp_src_i,
    input wire logic shdn_approved_i,
    input wire logic shdn_pol_pos_i,
    input wire logic temp_ilk_ctrl_i,
    input wire logic [11:0] current_setpoint_i,
    input wire logic [11:0] limit_serial_i,
    input wire logic [11:0] limit_memory_i,
    input wire logic [11:0] limit_ctrl_port_i,
    input wire logic [11:0] limit_pot_i,
    input wire logic limit_pot_sel_i,
    input wire logic temp_err_i,
    input wire logic serial_data_fail_i,
    input wire logic serial_timeout_i,
    input wire logic wrong_char_i,
    input wire logic [11:0] actual_diode_current_i,
    input wire logic hardware_err_i,
    input wire logic voltage_limit_err_i,
    input wire logic [11:0] diode_voltage_meas_i,
    input wire logic [11:0] panel_current_setpoint_i,
    input wire logic tec_temp_low_i,
    input wire logic tec_temp_high_i,
    input wire logic shutdown_active_i,
    input wire logic system_on_flag_i,
    input wire logic ctrl_if_ready_i,
    input wire logic safety_interlock_active_i,
    input wire logic local_mode_flag_i,
    input wire logic tec_interlock_active_i,
    input wire logic [79:0] tail_bytes_i,
    input wire logic tx_ready_i,
    output logic [7:0] tx_data_o,
    output logic tx_valid_o,
    output logic packet_done_o,
    output logic decoder_fault_err_o,
    output logic [11:0] limited_current_setpoint_o
);
    import status_pkg::*;

    tx_state_t state;
    logic [4:0] idx;
    logic [7:0] pkt [NUM_BYTES];
    logic [7:0] frame [NUM_BYTES];
    logic start;
    logic handshake;
    logic next_fault;
    logic [11:0] panel_code;
    limit_if lim_bus ();

    // Three-bit source fields have four legal one-hot-or-zero codes
    function automatic logic src3_ok(input logic [2:0] code);
        src3_ok = (code == SRC_SERIAL) || (code == SRC_MEMORY) || (code == SRC_CTRL) || (code == SRC_PANEL);
    endfunction

    // Limiter hookup
    assign lim_bus.setpoint = current_setpoint_i;
    assign lim_bus.lim_serial = limit_serial_i;
    assign lim_bus.lim_memory = limit_memory_i;
    assign lim_bus.lim_ctrl = limit_ctrl_port_i;
    assign lim_bus.lim_pot = limit_pot_i;
    assign lim_bus.lim_src = limit_src_i;
    assign lim_bus.use_pot = limit_pot_sel_i;

    setpoint_limiter u_limiter (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .lim(lim_bus)
    );

    assign start = (state == ST_IDLE) && send_i;
    assign handshake = tx_valid_o && tx_ready_i;
    // Any field outside its defined codes is a decoder fault
    assign next_fault = !(limit_src_i inside {LIM_SERIAL, LIM_MEMORY, LIM_CTRL}) || !src3_ok(setpoint_src_i)
        || !src3_ok(temp_src_i);
    // Panel field is reported as zero while not implemented
    assign panel_code = PANEL_SP_EN ? panel_current_setpoint_i : ZERO_CODE;

    // Byte image of the packet built from the live inputs
    always_comb
    begin
        for (int k = 0; k < NUM_BYTES; k++)
            frame[k] = ZERO_BYTE;
        frame[IDX_START1] = START_BYTE;
        frame[IDX_START2] = START_BYTE;
        frame[IDX_CON] = control_byte_i;
        frame[IDX_OM] = op_mode_byte_i;
        frame[IDX_DEC] = {temp_src_i, setpoint_src_i, limit_src_i};
        frame[IDX_IOC][IOC_SHDN_OK] = shdn_approved_i;
        frame[IDX_IOC][IOC_SHDN_POL] = shdn_pol_pos_i;
        frame[IDX_IOC][IOC_TEMP_ILK] = temp_ilk_ctrl_i;
        // Codes go out raw: step 0 is zero amperes, scaling is the host's job
        frame[IDX_SPL_LO] = lim_bus.limited[7:0];
        frame[IDX_SPL_HI] = {wrong_char_i, serial_timeout_i, serial_data_fail_i, temp_err_i,
            lim_bus.limited[11:8]};
        frame[IDX_ACT_LO] = actual_diode_current_i[7:0];
        frame[IDX_ACT_HI] = {next_fault, voltage_limit_err_i, 1'b0, hardware_err_i,
            actual_diode_current_i[11:8]};
        frame[IDX_DV_LO] = diode_voltage_meas_i[7:0];
        frame[IDX_DV_HI] = {system_on_flag_i, shutdown_active_i, tec_temp_high_i, tec_temp_low_i,
            diode_voltage_meas_i[11:8]};
        frame[IDX_PNL_LO] = panel_code[7:0];
        frame[IDX_PNL_HI] = {tec_interlock_active_i, local_mode_flag_i, safety_interlock_active_i,
            ctrl_if_ready_i, panel_code[11:8]};
        for (int k = 0; k < TAIL_BYTES; k++)
            frame[IDX_TAIL + k] = tail_bytes_i[8 * k +: 8];
        frame[IDX_STOP1] = STOP_BYTE;
        frame[IDX_STOP2] = STOP_BYTE;
    end

    // Packet state: idle until asked, then send until the last stop byte leaves
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            state <= ST_IDLE;
        else
            case (state)
                ST_IDLE:
                    if (send_i)
                        state <= ST_SEND;
                ST_SEND:
                    if (handshake && idx == LAST_IDX)
                        state <= ST_IDLE;
                default:
                    state <= ST_IDLE;
            endcase
    end

    // Snapshot so one packet never mixes old and new readings
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            for (int k = 0; k < NUM_BYTES; k++)
                pkt[k] <= ZERO_BYTE;
        end
        else if (start)
            pkt <= frame;
    end

    // Byte index
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i || start)
            idx <= FIRST_IDX;
        else if (handshake && idx != LAST_IDX)
            idx <= idx + IDX_STEP;
    end

    // Stream side; data holds while the sink stalls
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            tx_valid_o <= 1'b0;
            tx_data_o <= ZERO_BYTE;
        end
        else if (start)
        begin
            tx_valid_o <= 1'b1;
            tx_data_o <= frame[IDX_START1];
        end
        else if (handshake)
        begin
            if (idx == LAST_IDX)
                tx_valid_o <= 1'b0;
            else
                tx_data_o <= pkt[idx + IDX_STEP];
        end
    end

    // Done pulse and status mirrors
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            packet_done_o <= 1'b0;
            decoder_fault_err_o <= 1'b0;
            limited_current_setpoint_o <= ZERO_CODE;
        end
        else
        begin
            packet_done_o <= handshake && (idx == LAST_IDX);
            decoder_fault_err_o <= next_fault;
            limited_current_setpoint_o <= lim_bus.limited;
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);

    a_start_first: assert property (start |=> tx_valid_o && tx_data_o == START_BYTE)
        else $error("first byte is not the start byte");
    a_start_second: assert property (handshake && idx == FIRST_IDX |=> tx_data_o == START_BYTE)
        else $error("second byte is not the start byte");
    a_stop_bytes: assert property (tx_valid_o && idx >= 5'(IDX_STOP1) |-> tx_data_o == STOP_BYTE)
        else $error("closing bytes are not stop bytes");
    a_source_byte: assert property (start |=> pkt[IDX_DEC] ==
        {$past(temp_src_i), $past(setpoint_src_i), $past(limit_src_i)})
        else $error("source decoder byte wrong");
    a_fault_flag: assert property (start && next_fault |=> pkt[IDX_ACT_HI][7] && !pkt[IDX_ACT_HI][5])
        else $error("decoder fault not reported");
    a_ioc_layout: assert property (start |=> pkt[IDX_IOC] ==
        {4'h0, $past(temp_ilk_ctrl_i), $past(shdn_pol_pos_i), 1'b0, $past(shdn_approved_i)})
        else $error("in/out control byte wrong");
    a_setpoint_split: assert property (start |=> {pkt[IDX_SPL_HI][3:0], pkt[IDX_SPL_LO]} ==
        $past(lim_bus.limited))
        else $error("limited set point split wrong");
    a_err_nibble: assert property (start |=> pkt[IDX_SPL_HI][7:4] ==
        {$past(wrong_char_i), $past(serial_timeout_i), $past(serial_data_fail_i), $past(temp_err_i)})
        else $error("byte 8 error nibble wrong");
    a_actual_split: assert property (start |=> {pkt[IDX_ACT_HI][3:0], pkt[IDX_ACT_LO]} ==
        $past(actual_diode_current_i) && pkt[IDX_ACT_HI][6] == $past(voltage_limit_err_i))
        else $error("actual current bytes wrong");
    a_voltage_state: assert property (start |=> pkt[IDX_DV_HI] ==
        {$past(system_on_flag_i), $past(shutdown_active_i), $past(tec_temp_high_i), $past(tec_temp_low_i),
        $past(diode_voltage_meas_i[11:8])})
        else $error("byte 12 wrong");
    a_panel_state: assert property (start |=> pkt[IDX_PNL_HI][7:4] ==
        {$past(tec_interlock_active_i), $past(local_mode_flag_i), $past(safety_interlock_active_i),
        $past(ctrl_if_ready_i)} && (PANEL_SP_EN || pkt[IDX_PNL_LO] == ZERO_BYTE))
        else $error("byte 14 flags or panel field wrong");
    a_hold_stall: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("byte changed under stall");
    a_done_ends: assert property (handshake && idx == LAST_IDX |=> packet_done_o && !tx_valid_o)
        else $error("packet did not end after last byte");

    // Fault bit is per snapshot, so a clean packet must not carry it
    a_fault_clear: assert property (start && !next_fault |=> !pkt[IDX_ACT_HI][7])
        else $error("decoder fault set without cause");
    // Mirrors trail by one edge; the edge after reset still shows reset values
    a_fault_mirror: assert property (!$past(sys_rst_i) |-> decoder_fault_err_o == $past(next_fault))
        else $error("decoder fault mirror wrong");
    a_limit_mirror: assert property (!$past(sys_rst_i) |->
        limited_current_setpoint_o == $past(lim_bus.limited))
        else $error("limited set point mirror wrong");

    // Remaining fields of the snapshot
    a_byte10_flags: assert property (start |=> !pkt[IDX_ACT_HI][5] &&
        pkt[IDX_ACT_HI][4] == $past(hardware_err_i))
        else $error("byte 10 hardware or unused bit wrong");
    a_voltage_low: assert property (start |=> pkt[IDX_DV_LO] == $past(diode_voltage_meas_i[7:0]))
        else $error("diode voltage low byte wrong");
    // Panel field goes out as zeros unless the option is built in
    a_panel_low: assert property (start |=> pkt[IDX_PNL_LO] ==
        (PANEL_SP_EN ? $past(panel_current_setpoint_i[7:0]) : ZERO_BYTE))
        else $error("panel set point low byte wrong");
    a_panel_high: assert property (start |=> pkt[IDX_PNL_HI][3:0] ==
        (PANEL_SP_EN ? $past(panel_current_setpoint_i[11:8]) : ZERO_NIB))
        else $error("panel set point high nibble wrong");
    a_start_snapshot: assert property (start |=> pkt[IDX_START1] == START_BYTE && pkt[IDX_START2] == START_BYTE)
        else $error("start bytes missing from snapshot");
    a_stop_snapshot: assert property (start |=> pkt[IDX_STOP1] == STOP_BYTE && pkt[IDX_STOP2] == STOP_BYTE)
        else $error("stop bytes missing from snapshot");
    a_copy_bytes: assert property (start |=> pkt[IDX_CON] == $past(control_byte_i) &&
        pkt[IDX_OM] == $past(op_mode_byte_i))
        else $error("state bytes not copied");
    a_tail_ends: assert property (start |=> pkt[IDX_TAIL] == $past(tail_bytes_i[7:0]) &&
        pkt[IDX_STOP1 - 1] == $past(tail_bytes_i[79:72]))
        else $error("tail bytes misplaced");

    // A running packet never picks up new readings or a new request
    a_pkt_frozen: assert property (state == ST_SEND |=> $stable(pkt[IDX_SPL_HI]) &&
        $stable(pkt[IDX_ACT_HI]) && $stable(pkt[IDX_DV_HI]))
        else $error("snapshot changed mid packet");
    a_busy_ignores: assert property (state == ST_SEND && !(handshake && idx == LAST_IDX) |=> state == ST_SEND)
        else $error("packet left before its last byte");
    a_idle_quiet: assert property (state == ST_IDLE |-> !tx_valid_o)
        else $error("valid while idle");
    a_index_step: assert property (handshake && idx != LAST_IDX |=> idx == $past(idx) + IDX_STEP)
        else $error("byte index skipped");
    a_done_pulse: assert property (packet_done_o |=> !packet_done_o)
        else $error("done pulse longer than one cycle");

    c_packet_sent: cover property (start ##[1:60] packet_done_o);
    c_stalled_byte: cover property (tx_valid_o && !tx_ready_i [*3] ##1 handshake);
    c_fault_sent: cover property (start && next_fault);
    // Restart is taken in the very cycle the done pulse shows
    c_back_to_back: cover property (packet_done_o && start);
    c_pot_limit: cover property (start && limit_pot_sel_i);
endmodule

// ===== rtl/limit_if.sv
/*
 Carrier between the framer and the set point limiter.
 Assumes both ends share the framer clock.
*/
`timescale 1ns/1ps
interface limit_if;
    logic [11:0] setpoint;
    logic [11:0] lim_serial;
    logic [11:0] lim_memory;
    logic [11:0] lim_ctrl;
    logic [11:0] lim_pot;
    logic [1:0] lim_src;
    logic use_pot;
    logic [11:0] limited;
    modport framer (output setpoint, lim_serial, lim_memory, lim_ctrl, lim_pot, lim_src, use_pot, input limited);
    modport limiter (input setpoint, lim_serial, lim_memory, lim_ctrl, lim_pot, lim_src, use_pot, output limited);
endinterface

// ===== rtl/setpoint_limiter.sv
/*
 Clamps the diode current set point to the active limit, registered.
 Assumes the limit inputs are synchronous to clock_i.
*/
`timescale 1ns/1ps
module setpoint_limiter (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    limit_if.limiter lim
);
    import status_pkg::*;
    logic [11:0] act_limit;

    // Potentiometer wins; undefined code falls back to the serial limit
    always_comb
    begin
        act_limit = lim.lim_serial;
        if (lim.use_pot)
            act_limit = lim.lim_pot;
        else if (lim.lim_src == LIM_MEMORY)
            act_limit = lim.lim_memory;
        else if (lim.lim_src == LIM_CTRL)
            act_limit = lim.lim_ctrl;
    end

    // Clamp, one cycle of latency
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            lim.limited <= ZERO_CODE;
        else if (lim.setpoint > act_limit)
            lim.limited <= act_limit;
        else
            lim.limited <= lim.setpoint;
    end

    a_limit_clamp: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !$past(sys_rst_i) |-> lim.limited == (($past(lim.setpoint) > $past(act_limit)) ?
        $past(act_limit) : $past(lim.setpoint)))
        else $error("limited set point not clamped");
endmodule

// ===== rtl/status_pkg.sv
/*
 Constants, field layouts and state codes for the status packet framer.
 Assumes one 25 MHz clock; the byte sink (a UART) sits outside.
*/
package status_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int NUM_BYTES = 26;
    localparam logic [4:0] LAST_IDX = 5'h19;
    localparam logic [4:0] FIRST_IDX = 5'h00;
    localparam logic [4:0] IDX_STEP = 5'h01;
    // Byte positions, counted from zero
    localparam int IDX_START1 = 0;
    localparam int IDX_START2 = 1;
    localparam int IDX_CON = 2;
    localparam int IDX_OM = 3;
    localparam int IDX_DEC = 4;
    localparam int IDX_IOC = 5;
    localparam int IDX_SPL_LO = 6;
    localparam int IDX_SPL_HI = 7;
    localparam int IDX_ACT_LO = 8;
    localparam int IDX_ACT_HI = 9;
    localparam int IDX_DV_LO = 10;
    localparam int IDX_DV_HI = 11;
    localparam int IDX_PNL_LO = 12;
    localparam int IDX_PNL_HI = 13;
    localparam int IDX_TAIL = 14;
    localparam int TAIL_BYTES = 10;
    localparam int IDX_STOP1 = 24;
    localparam int IDX_STOP2 = 25;
    localparam logic [7:0] START_BYTE = 8'h0a;
    localparam logic [7:0] STOP_BYTE = 8'h0b;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // Source decoder codes
    localparam logic [2:0] SRC_SERIAL = 3'h0;
    localparam logic [2:0] SRC_MEMORY = 3'h1;
    localparam logic [2:0] SRC_CTRL = 3'h2;
    localparam logic [2:0] SRC_PANEL = 3'h4;
    localparam logic [1:0] LIM_SERIAL = 2'h0;
    localparam logic [1:0] LIM_MEMORY = 2'h1;
    localparam logic [1:0] LIM_CTRL = 2'h2;
    // In/out control byte bit positions
    localparam int IOC_SHDN_OK = 0;
    localparam int IOC_SHDN_POL = 2;
    localparam int IOC_TEMP_ILK = 3;
    // Scaling of codes, in micro-amps and nano-volts per step
    localparam int CUR_STEP_UA_50A = 12210;
    localparam int CUR_STEP_UA_60A = 14650;
    localparam int VOLT_STEP_NV = 6105010;
    localparam logic [11:0] ZERO_CODE = 12'h000;
    localparam logic [3:0] ZERO_NIB = 4'h0;
    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SEND = 2'b10} tx_state_t;
endpackage

// ===== tb/host_sink.sv
/*
 Host side byte sink for the status packet framer, with optional back-pressure.
 Assumes one clock shared with the framer and a valid/ready byte handshake.
*/
`timescale 1ns/1ps
module host_sink (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic stall_en_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o
);
    logic [7:0] rx_q[$];
    logic [7:0] lfsr;
    // Pattern generator; a slow host drops ready on some cycles
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            lfsr <= 8'h5b;
        else
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end
    // Ready changes only after an edge, since it comes from registers
    assign tx_ready_o = !sys_rst_i && (!stall_en_i || lfsr[1]);
    // Collect every byte taken on a handshake edge
    always @(posedge clock_i)
    begin
        if (!sys_rst_i && tx_valid_i && tx_ready_o)
            rx_q.push_back(tx_data_i);
    end
endmodule

// ===== tb/laser_driver_status_packet_tb_top.sv
/*
 Self-checking bench for the status packet framer.
 Assumes host_sink as the byte sink and the status_pkg constants.
*/
`timescale 1ns/1ps
module laser_driver_status_packet_tb_top;
    import status_pkg::*;
    logic clock_i = 1'b0, sys_rst_i = 1'b1, send_i = 1'b0, stall_en = 1'b0;
    logic [7:0] control_byte_i, op_mode_byte_i, tx_data_o;
    logic [1:0] limit_src_i;
    logic [2:0] setpoint_src_i, temp_src_i;
    logic shdn_approved_i, shdn_pol_pos_i, temp_ilk_ctrl_i, limit_pot_sel_i;
    logic [11:0] current_setpoint_i, limit_serial_i, limit_memory_i, limit_ctrl_port_i, limit_pot_i;
    logic temp_err_i, serial_data_fail_i, serial_timeout_i, wrong_char_i, hardware_err_i, voltage_limit_err_i;
    logic [11:0] actual_diode_current_i, diode_voltage_meas_i, panel_current_setpoint_i, limited_current_setpoint_o;
    logic tec_temp_low_i, tec_temp_high_i, shutdown_active_i, system_on_flag_i;
    logic ctrl_if_ready_i, safety_interlock_active_i, local_mode_flag_i, tec_interlock_active_i;
    logic [79:0] tail_bytes_i;
    logic tx_ready_i, tx_valid_o, packet_done_o, decoder_fault_err_o;
    logic [7:0] exp_b[26];
    int fails = 0;
    int cmp_count = 0;
    integer seed = 32'hf12218ae;

    laser_driver_status_packet dut (
        .clock_i, .sys_rst_i, .send_i, .control_byte_i, .op_mode_byte_i, .limit_src_i, .setpoint_src_i,
        .temp_src_i, .shdn_approved_i, .shdn_pol_pos_i, .temp_ilk_ctrl_i, .current_setpoint_i, .limit_serial_i,
        .limit_memory_i, .limit_ctrl_port_i, .limit_pot_i, .limit_pot_sel_i, .temp_err_i, .serial_data_fail_i,
        .serial_timeout_i, .wrong_char_i, .actual_diode_current_i, .hardware_err_i, .voltage_limit_err_i,
        .diode_voltage_meas_i, .panel_current_setpoint_i, .tec_temp_low_i, .tec_temp_high_i, .shutdown_active_i,
        .system_on_flag_i, .ctrl_if_ready_i, .safety_interlock_active_i, .local_mode_flag_i,
        .tec_interlock_active_i, .tail_bytes_i, .tx_ready_i, .tx_data_o, .tx_valid_o, .packet_done_o,
        .decoder_fault_err_o, .limited_current_setpoint_o);
    host_sink host (.clock_i, .sys_rst_i, .stall_en_i(stall_en), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
        .tx_ready_o(tx_ready_i));

    // 25 MHz clock
    always #20 clock_i = !clock_i;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Limit selection and clamp as the host would reckon it
    function automatic logic [11:0] clamp_exp();
        logic [11:0] lim;
        if (limit_pot_sel_i)
            lim = limit_pot_i;
        else if (limit_src_i == LIM_MEMORY)
            lim = limit_memory_i;
        else if (limit_src_i == LIM_CTRL)
            lim = limit_ctrl_port_i;
        else
            lim = limit_serial_i;
        return (current_setpoint_i < lim) ? current_setpoint_i : lim;
    endfunction

    function automatic logic code_bad(input logic [2:0] c);
        return !(c inside {SRC_SERIAL, SRC_MEMORY, SRC_CTRL, SRC_PANEL});
    endfunction

    function automatic logic fault_exp();
        return (limit_src_i == 2'h3) || code_bad(setpoint_src_i) || code_bad(temp_src_i);
    endfunction

    // Random fields, fixed decoder codes; sometimes set point equals the serial limit
    task automatic rand_inputs(input logic [2:0] sp, input logic [2:0] tp, input logic [1:0] ls);
        logic [255:0] rv;
        for (int k = 0; k < 8; k++)
            rv[k*32 +: 32] = $random(seed);
        // One draw in four lands the set point on the serial limit, set once
        if (rv[211:210] == 2'h0)
            rv[23:12] = rv[11:0];
        {control_byte_i, op_mode_byte_i, current_setpoint_i, limit_serial_i} <= rv[39:0];
        {limit_memory_i, limit_ctrl_port_i, limit_pot_i, actual_diode_current_i} <= rv[87:40];
        {diode_voltage_meas_i, panel_current_setpoint_i, tail_bytes_i} <= rv[191:88];
        {shdn_approved_i, shdn_pol_pos_i, temp_ilk_ctrl_i, limit_pot_sel_i, temp_err_i, serial_data_fail_i,
            serial_timeout_i, wrong_char_i} <= rv[199:192];
        {hardware_err_i, voltage_limit_err_i, tec_temp_low_i, tec_temp_high_i, shutdown_active_i,
            system_on_flag_i} <= rv[205:200];
        {ctrl_if_ready_i, safety_interlock_active_i, local_mode_flag_i, tec_interlock_active_i} <= rv[209:206];
        {temp_src_i, setpoint_src_i, limit_src_i} <= {tp, sp, ls};
    endtask

    task automatic build_exp();
        logic [11:0] spl;
        spl = clamp_exp();
        exp_b[0] = START_BYTE;
        exp_b[1] = START_BYTE;
        exp_b[2] = control_byte_i;
        exp_b[3] = op_mode_byte_i;
        exp_b[4] = {temp_src_i, setpoint_src_i, limit_src_i};
        exp_b[5] = {4'h0, temp_ilk_ctrl_i, shdn_pol_pos_i, 1'b0, shdn_approved_i};
        exp_b[6] = spl[7:0];
        exp_b[7] = {wrong_char_i, serial_timeout_i, serial_data_fail_i, temp_err_i, spl[11:8]};
        exp_b[8] = actual_diode_current_i[7:0];
        exp_b[9] = {fault_exp(), voltage_limit_err_i, 1'b0, hardware_err_i, actual_diode_current_i[11:8]};
        exp_b[10] = diode_voltage_meas_i[7:0];
        exp_b[11] = {system_on_flag_i, shutdown_active_i, tec_temp_high_i, tec_temp_low_i,
            diode_voltage_meas_i[11:8]};
        exp_b[12] = ZERO_BYTE;
        exp_b[13] = {tec_interlock_active_i, local_mode_flag_i, safety_interlock_active_i, ctrl_if_ready_i,
            ZERO_NIB};
        for (int i = 0; i < TAIL_BYTES; i++)
            exp_b[IDX_TAIL + i] = tail_bytes_i[i*8 +: 8];
        exp_b[IDX_STOP1] = STOP_BYTE;
        exp_b[IDX_STOP2] = STOP_BYTE;
    endtask

    task automatic cmp_pkt(input int base);
        for (int i = 0; i < NUM_BYTES; i++)
            chk(32'(host.rx_q[base + i]), 32'(exp_b[i]), "packet byte");
    endtask

    // Bounded wait for the end-of-packet pulse
    task automatic wait_done();
        int n;
        n = 0;
        do
        begin
            @(posedge clock_i);
            #1;
            n++;
        end
        while (packet_done_o !== 1'b1 && n < 500);
        chk(32'(packet_done_o), 32'h1, "packet done");
        chk(32'(tx_valid_o), 32'h0, "valid after last byte");
    endtask

    // One packet; inputs scrambled after the send edge, plus a send that must be ignored
    task automatic run_packet(input logic [2:0] sp, input logic [2:0] tp, input logic [1:0] ls, input logic st);
        rand_inputs(sp, tp, ls);
        stall_en <= st;
        repeat (3) @(posedge clock_i);
        #1;
        chk(32'(limited_current_setpoint_o), 32'(clamp_exp()), "limited set point");
        chk(32'(decoder_fault_err_o), 32'(fault_exp()), "decoder fault");
        build_exp();
        host.rx_q.delete();
        @(posedge clock_i);
        send_i <= 1'b1;
        @(posedge clock_i);
        send_i <= 1'b0;
        rand_inputs(3'h7, 3'h7, 2'h3);
        repeat (5) @(posedge clock_i);
        send_i <= 1'b1;
        @(posedge clock_i);
        send_i <= 1'b0;
        wait_done();
        chk(32'(host.rx_q.size()), 32'(NUM_BYTES), "byte count");
        cmp_pkt(0);
        repeat (4) @(posedge clock_i);
        #1;
        chk(32'(tx_valid_o), 32'h0, "send during packet ignored");
        // Next stimulus starts on an edge again
        @(posedge clock_i);
    endtask

    initial
    begin
        logic [31:0] r;
        rand_inputs(SRC_SERIAL, SRC_SERIAL, LIM_SERIAL);
        // Twelve edges with reset high, the last one releasing it
        repeat (11) @(posedge clock_i);
        #1;
        chk(32'({tx_valid_o, packet_done_o, decoder_fault_err_o}), 32'h0, "reset flags");
        chk(32'(limited_current_setpoint_o), 32'h0, "reset limit");
        @(posedge clock_i);
        sys_rst_i <= 1'b0;
        // Every decoder code, stalls on odd passes
        for (int c = 0; c < 8; c++)
            run_packet(3'(c), 3'(7 - c), 2'(c), c[0]);
        $display("test decoder codes done");
        for (int c = 0; c < 6; c++)
        begin
            r = $random(seed);
            run_packet(r[2:0], r[5:3], r[7:6], r[8]);
        end
        $display("test random packets done");
        // Send held high gives two packets with one idle cycle between
        rand_inputs(SRC_PANEL, SRC_CTRL, LIM_MEMORY);
        stall_en <= 1'b0;
        repeat (3) @(posedge clock_i);
        build_exp();
        host.rx_q.delete();
        send_i <= 1'b1;
        wait_done();
        wait_done();
        send_i <= 1'b0;
        chk(32'(host.rx_q.size()), 32'(2 * NUM_BYTES), "back to back count");
        cmp_pkt(0);
        cmp_pkt(NUM_BYTES);
        $display("test back to back done");
        give_verdict();
    end

    // Watchdog, far beyond the expected run of under a thousand cycles
    initial
    begin
        #2000000;
        fails++;
        $display("unexpected at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule
